// File: rst_ctl_pkg.sv
package rst_ctl_pkg;

  // register map: one 16-bit register on the plain port, index 0x0D
  localparam logic [7:0]  RESET_CTL_ADDR   = 8'h0D;
  localparam logic [15:0] RESET_CTL_RST    = 16'h0000;

  // field positions
  localparam int          ALT_ADDR_BIT     = 10;
  localparam int          AUTO_RESTART_BIT = 9;
  localparam int          PASS_BAD_BIT     = 8;
  localparam int          POLICY_HI_BIT    = 7;
  localparam int          POLICY_LO_BIT    = 6;
  localparam int          SUB_RST_BIT      = 5;
  localparam int          TRISTATE_BIT     = 4;
  // bits owned by this block; others read as zero
  localparam logic [15:0] OWNED_MASK       = 16'h07F0;

  // serial-bus address pairs (write/read)
  localparam logic [7:0]  ALT_ADDR_WR      = 8'h90;
  localparam logic [7:0]  ALT_ADDR_RD      = 8'h91;
  localparam logic [7:0]  DEF_ADDR_WR      = 8'hBA;
  localparam logic [7:0]  DEF_ADDR_RD      = 8'hBB;

  // standby pin policy codes
  localparam logic [1:0]  POL_STBY_A       = 2'h0;
  localparam logic [1:0]  POL_STBY_B       = 2'h1;
  localparam logic [1:0]  POL_HIZ_ONLY     = 2'h2;
  localparam logic [1:0]  POL_IGNORE       = 2'h3;

  // software register port
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

  // frame events from the sensor core timing
  typedef struct packed {
    logic frame_start;
    logic geom_change;
  } frame_evt_type;

  typedef enum logic [2:0] {
    ST_GOOD    = 3'b001,
    ST_BAD     = 3'b010,
    ST_RESTART = 3'b100
  } frame_state_type;

endpackage

// File: sensor_reset_standby_control.sv
`timescale 1ns/1ps
// Contract
// - alt select answers at pair 0x90/0x91
// - alt select writes ignored during standby
// - auto restart forces restart on bad frame
// - auto restart waits integration, not frame
// - pass field 1 outputs all frames
// - pass field 0 suppresses bad frames
// - first frame after geometry change is bad
// - policy 00/01: standby plus high impedance
// - policy 10: high impedance only
// - policy 11: standby input ignored
// - subsystem reset field 1 holds subsystem
// - subsystem leaves reset on write 0
// - tristate field floats pixel outputs
// - tristate acts only with policy bit 6
module sensor_reset_standby_control
  import rst_ctl_pkg::*;
(
  input  wire logic          clk,            // 200 MHz master clock
  input  wire logic          srst,           // synchronous reset, active high
  input  wire reg_req_type   req,            // register port request
  output logic [15:0]        rdata,          // read data, cycle after read strobe
  input  wire logic          standby_in,     // external standby pin level
  input  wire frame_evt_type evt,            // frame start and setting-change pulses
  input  wire logic          integ_done,     // integration time elapsed after restart
  output logic [7:0]         bus_addr_wr,    // serial-bus write address
  output logic [7:0]         bus_addr_rd,    // serial-bus read address
  output logic               standby_active, // device in standby
  output logic               pins_oe_n,      // pixel pins enable, low while driven
  output logic               frame_restart,  // one-cycle restart request
  output logic               frame_out_en,   // current frame passed to output
  output logic               subsys_rst      // processor subsystem reset
);

  logic [15:0]     ctl_r;
  logic [1:0]      policy;
  logic            stby_req;
  logic            hiz_req;
  frame_state_type fstate_r;
  logic            bad_now;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == RESET_CTL_ADDR);
  endfunction

  // control register write; fields apply on the next edge, no frame sync
  always_ff @(posedge clk)
  begin
    if (srst)
      ctl_r <= RESET_CTL_RST;
    else if (req.wr && hit(req.addr))
    begin
      ctl_r[AUTO_RESTART_BIT:TRISTATE_BIT] <= req.wdata[AUTO_RESTART_BIT:TRISTATE_BIT];
      if (!stby_req)
        ctl_r[ALT_ADDR_BIT] <= req.wdata[ALT_ADDR_BIT];
    end
  end

  // read port: one cycle latency; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata <= 16'h0000;
    else if (req.rd && hit(req.addr))
      rdata <= ctl_r & OWNED_MASK;
    else
      rdata <= 16'h0000;
  end

  // address pair select
  assign bus_addr_wr = ctl_r[ALT_ADDR_BIT] ? ALT_ADDR_WR : DEF_ADDR_WR;
  assign bus_addr_rd = ctl_r[ALT_ADDR_BIT] ? ALT_ADDR_RD : DEF_ADDR_RD;

  // standby pin policy decode
  assign policy = ctl_r[POLICY_HI_BIT:POLICY_LO_BIT];
  always_comb
  begin
    stby_req = 1'b0;
    hiz_req  = 1'b0;
    case (policy)
      POL_STBY_A, POL_STBY_B:
      begin
        stby_req = standby_in;
        hiz_req  = standby_in;
      end
      POL_HIZ_ONLY: hiz_req = standby_in;
      default: ;
    endcase
  end

  assign standby_active = stby_req;
  // tristate field only gates pins when policy bit 6 is set
  assign pins_oe_n = hiz_req | (ctl_r[TRISTATE_BIT] & ctl_r[POLICY_LO_BIT]);
  assign subsys_rst = ctl_r[SUB_RST_BIT];

  // bad-frame tracking: a change marks the next frame bad
  logic pend_bad_r;
  always_ff @(posedge clk)
  begin
    if (srst)
      pend_bad_r <= 1'b0;
    else if (evt.geom_change)
      pend_bad_r <= 1'b1;
    else if (evt.frame_start)
      pend_bad_r <= 1'b0;
  end

  assign bad_now = evt.frame_start && (pend_bad_r || evt.geom_change);

  // frame state: restart shortens wait to one integration time
  always_ff @(posedge clk)
  begin
    if (srst)
      fstate_r <= ST_GOOD;
    else
    begin
      case (fstate_r)
        ST_GOOD, ST_BAD:
          if (evt.frame_start)
          begin
            if (!bad_now)
              fstate_r <= ST_GOOD;
            else if (ctl_r[AUTO_RESTART_BIT])
              fstate_r <= ST_RESTART;
            else
              fstate_r <= ST_BAD;
          end
        ST_RESTART:
          if (integ_done)
            fstate_r <= ST_GOOD;
        default: fstate_r <= ST_GOOD;
      endcase
    end
  end

  assign frame_restart = bad_now && ctl_r[AUTO_RESTART_BIT];
  assign frame_out_en  = ctl_r[PASS_BAD_BIT] || (fstate_r == ST_GOOD);

  // checks
  alt_addr_map_a: assert property (@(posedge clk) disable iff (srst)
    ctl_r[ALT_ADDR_BIT] |-> (bus_addr_wr == 8'h90 && bus_addr_rd == 8'h91))
    else $error("alt address pair wrong");
  alt_write_block_a: assert property (@(posedge clk) disable iff (srst)
    (req.wr && hit(req.addr) && stby_req) |=> $stable(ctl_r[ALT_ADDR_BIT]))
    else $error("alt select changed in standby");
  restart_force_a: assert property (@(posedge clk) disable iff (srst)
    (bad_now && ctl_r[AUTO_RESTART_BIT]) |-> frame_restart ##1 fstate_r == ST_RESTART)
    else $error("no restart on bad frame");
  restart_wait_a: assert property (@(posedge clk) disable iff (srst)
    (fstate_r == ST_RESTART && integ_done) |=> fstate_r == ST_GOOD)
    else $error("restart wait not integration");
  pass_all_a: assert property (@(posedge clk) disable iff (srst)
    ctl_r[PASS_BAD_BIT] |-> frame_out_en)
    else $error("frame blocked with pass set");
  suppress_bad_a: assert property (@(posedge clk) disable iff (srst)
    (!ctl_r[PASS_BAD_BIT] && fstate_r != ST_GOOD) |-> !frame_out_en)
    else $error("bad frame passed");
  bad_mark_a: assert property (@(posedge clk) disable iff (srst)
    (evt.geom_change && !evt.frame_start && !ctl_r[AUTO_RESTART_BIT])
      ##1 (evt.frame_start && !evt.geom_change && !ctl_r[AUTO_RESTART_BIT])
      |=> fstate_r == ST_BAD)
    else $error("frame after change not bad");
  stby_policy_a: assert property (@(posedge clk) disable iff (srst)
    (policy[1] == 1'b0 && standby_in) |-> (standby_active && pins_oe_n))
    else $error("standby policy 0x wrong");
  hiz_only_a: assert property (@(posedge clk) disable iff (srst)
    (policy == POL_HIZ_ONLY && standby_in) |-> (!standby_active && pins_oe_n))
    else $error("policy 10 wrong");
  ignore_stby_a: assert property (@(posedge clk) disable iff (srst)
    (policy == POL_IGNORE) |-> !standby_active)
    else $error("standby not ignored");
  subsys_hold_a: assert property (@(posedge clk) disable iff (srst)
    (req.wr && hit(req.addr) && req.wdata[SUB_RST_BIT]) |=> subsys_rst)
    else $error("subsystem not reset");
  subsys_exit_a: assert property (@(posedge clk) disable iff (srst)
    $fell(subsys_rst) |-> $past(req.wr && hit(req.addr) && !req.wdata[SUB_RST_BIT]))
    else $error("subsystem left reset unasked");
  tristate_gate_a: assert property (@(posedge clk) disable iff (srst)
    (!standby_in && !ctl_r[POLICY_LO_BIT]) |-> !pins_oe_n)
    else $error("tristate without bit 6");
  tristate_on_a: assert property (@(posedge clk) disable iff (srst)
    (ctl_r[TRISTATE_BIT] && ctl_r[POLICY_LO_BIT]) |-> pins_oe_n)
    else $error("tristate not applied");
  readback_a: assert property (@(posedge clk) disable iff (srst)
    (req.rd && hit(req.addr)) |=> rdata == ($past(ctl_r) & OWNED_MASK))
    else $error("readback mismatch");

  // read port side: the data word is zero outside the answer cycle, so a stale
  // value can never be mistaken for a fresh read
  rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
    !(req.rd && hit(req.addr)) |=> rdata == 16'h0000)
    else $error("read data not idle");

  // bits outside this block's fields always read as zero
  reserved_zero_a: assert property (@(posedge clk) disable iff (srst)
    (rdata & ~OWNED_MASK) == 16'h0000)
    else $error("reserved bits not zero");

  // a written field lands on the next edge, no frame start needed
  field_write_a: assert property (@(posedge clk) disable iff (srst)
    (req.wr && hit(req.addr))
      |=> ctl_r[AUTO_RESTART_BIT:TRISTATE_BIT] == $past(req.wdata[AUTO_RESTART_BIT:TRISTATE_BIT]))
    else $error("field write lost");

  // without a write the register holds its value
  ctl_hold_a: assert property (@(posedge clk) disable iff (srst)
    !(req.wr && hit(req.addr)) |=> $stable(ctl_r))
    else $error("register changed unasked");

  // outside standby the alternate select follows the written bit
  alt_write_a: assert property (@(posedge clk) disable iff (srst)
    (req.wr && hit(req.addr) && !stby_req)
      |=> ctl_r[ALT_ADDR_BIT] == $past(req.wdata[ALT_ADDR_BIT]))
    else $error("alt select write lost");

  // with the select clear the default pair answers
  default_addr_a: assert property (@(posedge clk) disable iff (srst)
    !ctl_r[ALT_ADDR_BIT] |-> (bus_addr_wr == DEF_ADDR_WR && bus_addr_rd == DEF_ADDR_RD))
    else $error("default address pair wrong");

  // restart request is a pulse tied to a frame start
  restart_pulse_a: assert property (@(posedge clk) disable iff (srst)
    frame_restart |-> evt.frame_start)
    else $error("restart outside frame start");

  // restart only when auto restart is enabled
  restart_auto_a: assert property (@(posedge clk) disable iff (srst)
    frame_restart |-> ctl_r[AUTO_RESTART_BIT])
    else $error("restart without enable");

  // state register never holds an illegal code
  state_onehot_a: assert property (@(posedge clk) disable iff (srst)
    $onehot(fstate_r))
    else $error("frame state not one-hot");

  // the restart wait ends only on the integration pulse
  restart_hold_a: assert property (@(posedge clk) disable iff (srst)
    (fstate_r == ST_RESTART && !integ_done) |=> fstate_r == ST_RESTART)
    else $error("restart wait cut short");

  // a good frame is always shown
  good_pass_a: assert property (@(posedge clk) disable iff (srst)
    (fstate_r == ST_GOOD) |-> frame_out_en)
    else $error("good frame blocked");

  // a clean frame start outside the restart wait returns the state to good
  bad_clear_a: assert property (@(posedge clk) disable iff (srst)
    (evt.frame_start && !bad_now && fstate_r != ST_RESTART) |=> fstate_r == ST_GOOD)
    else $error("good frame marked bad");

  // good state holds until the next frame start
  good_stay_a: assert property (@(posedge clk) disable iff (srst)
    (fstate_r == ST_GOOD && !evt.frame_start) |=> fstate_r == ST_GOOD)
    else $error("good state left early");

  // a setting change always arms the bad-frame mark
  pend_set_a: assert property (@(posedge clk) disable iff (srst)
    evt.geom_change |=> pend_bad_r)
    else $error("change not remembered");

  // standby never entered while the pin is low
  stby_low_a: assert property (@(posedge clk) disable iff (srst)
    !standby_in |-> !standby_active)
    else $error("standby without pin");

  // standby always floats the outputs
  stby_oe_a: assert property (@(posedge clk) disable iff (srst)
    standby_active |-> pins_oe_n)
    else $error("standby with pins driven");

  // ignored pin leaves the outputs driven unless tristate is asked
  ignore_oe_a: assert property (@(posedge clk) disable iff (srst)
    (policy == POL_IGNORE && !ctl_r[TRISTATE_BIT]) |-> !pins_oe_n)
    else $error("pins floated with pin ignored");

  // subsystem stays in reset until a write clears it
  subsys_keep_a: assert property (@(posedge clk) disable iff (srst)
    (subsys_rst && !(req.wr && hit(req.addr))) |=> subsys_rst)
    else $error("subsystem left reset early");

  // no float request means the pins are driven
  oe_idle_a: assert property (@(posedge clk) disable iff (srst)
    (!hiz_req && !(ctl_r[TRISTATE_BIT] && ctl_r[POLICY_LO_BIT])) |-> !pins_oe_n)
    else $error("pins floated unasked");

  // main scenarios
  restart_seen_c: cover property (@(posedge clk) disable iff (srst) frame_restart);
  hiz_only_c: cover property (@(posedge clk) disable iff (srst)
    policy == POL_HIZ_ONLY && standby_in);
  alt_blocked_c: cover property (@(posedge clk) disable iff (srst)
    req.wr && hit(req.addr) && stby_req);
  // a bad frame shown because pass is set
  bad_shown_c: cover property (@(posedge clk) disable iff (srst)
    ctl_r[PASS_BAD_BIT] && fstate_r == ST_BAD);
  // subsystem held in reset
  subsys_held_c: cover property (@(posedge clk) disable iff (srst)
    subsys_rst);

endmodule // sensor_reset_standby_control

// File: host_port_model.sv
`timescale 1ns/1ps
// host on the register port; strobes last one cycle and change just after an edge
module host_port_model
  import rst_ctl_pkg::*;
(
  input  wire logic        clk,   // master clock
  input  wire logic [15:0] rdata, // read data from block
  output reg_req_type      req    // request to block
);
  initial req = '0;
  // one-cycle write to any address a; the test also writes 0x0E and sets the subsystem reset bit
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // host_port_model

// File: test_sensor_reset_standby_control.sv
`timescale 1ns/1ps
module test_sensor_reset_standby_control
  import rst_ctl_pkg::*;
;
  logic          clk        = 1'b0;
  logic          srst       = 1'b1;
  logic          standby_in = 1'b0;
  logic          integ_done = 1'b0;
  frame_evt_type evt        = '0;
  reg_req_type   req;
  logic [15:0]   rdata, d;
  logic [7:0]    bus_addr_wr, bus_addr_rd;
  logic          standby_active, pins_oe_n, frame_restart, frame_out_en, subsys_rst, rs;
  int            n_fail = 0, num_checks = 0, cyc = 0;
  // 200 MHz
  always #2.5 clk = ~clk;
  host_port_model host (.clk(clk), .rdata(rdata), .req(req));
  sensor_reset_standby_control uut (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .standby_in(standby_in), .evt(evt), .integ_done(integ_done), .bus_addr_wr(bus_addr_wr),
    .bus_addr_rd(bus_addr_rd), .standby_active(standby_active), .pins_oe_n(pins_oe_n),
    .frame_restart(frame_restart), .frame_out_en(frame_out_en), .subsys_rst(subsys_rst));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // a hang costs a mismatch; the tests need well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done();
    end
  end
  // frame with optional setting change before it; restart sampled in the start cycle
  task automatic frame(input logic g);
    @(posedge clk);
    evt <= '{frame_start: 1'b0, geom_change: g};
    @(posedge clk);
    evt <= '{frame_start: 1'b1, geom_change: 1'b0};
    #1 rs = frame_restart;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask
  task automatic t_regs;
    host.rd(RESET_CTL_ADDR, d);
    chk(d, RESET_CTL_RST);
    chk({bus_addr_wr, bus_addr_rd}, {DEF_ADDR_WR, DEF_ADDR_RD});
    host.wr(RESET_CTL_ADDR, 16'hFFFF);
    #1 chk({bus_addr_wr, bus_addr_rd}, {ALT_ADDR_WR, ALT_ADDR_RD});
    chb(subsys_rst, 1'b1);
    host.wr(8'h0E, 16'h0000);
    host.rd(8'h0E, d);
    chk(d, 16'h0000);
    host.rd(RESET_CTL_ADDR, d);
    chk(d, OWNED_MASK);
    host.wr(RESET_CTL_ADDR, 16'h0000);
    #1 chb(subsys_rst, 1'b0);
    $display("test regs done");
  endtask
  task automatic t_standby;
    for (int p = 0; p < 4; p++)
    begin
      standby_in <= 1'b0;
      host.wr(RESET_CTL_ADDR, 16'(p) << 6);
      standby_in <= 1'b1;
      @(posedge clk);
      #1 chk({standby_active, pins_oe_n}, {p < 2, p != 3});
    end
    host.wr(RESET_CTL_ADDR, 16'h0000);
    host.wr(RESET_CTL_ADDR, 16'h0400);
    #1 chk({bus_addr_wr, bus_addr_rd}, {DEF_ADDR_WR, DEF_ADDR_RD});
    standby_in <= 1'b0;
    host.wr(RESET_CTL_ADDR, 16'h0010);
    #1 chb(pins_oe_n, 1'b0);
    host.wr(RESET_CTL_ADDR, 16'h0050);
    #1 chb(pins_oe_n, 1'b1);
    $display("test standby done");
  endtask
  task automatic t_frames;
    host.wr(RESET_CTL_ADDR, 16'h0000);
    frame(1'b1);
    chb(rs, 1'b0);
    chb(frame_out_en, 1'b0);
    frame(1'b0);
    chb(frame_out_en, 1'b1);
    host.wr(RESET_CTL_ADDR, 16'h0100);
    frame(1'b1);
    chb(frame_out_en, 1'b1);
    host.wr(RESET_CTL_ADDR, 16'h0200);
    frame(1'b1);
    chb(rs, 1'b1);
    chb(frame_out_en, 1'b0);
    integ_done <= 1'b1;
    @(posedge clk);
    integ_done <= 1'b0;
    #1 chb(frame_out_en, 1'b1);
    $display("test frames done");
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_standby();
    t_frames();
    test_done();
  end
endmodule // test_sensor_reset_standby_control
